// file: rli_access.sv
module rli_access (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // host register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // oscillator timebase and status
  input wire logic i_osc_clk,
  input wire logic i_clock_valid,
  input wire logic i_load_ready,
  input wire logic i_osc_fail,
  // oscillator controls
  output logic o_osc_power,
  output logic o_osc_crystal,
  output logic o_bias_double,
  output logic o_gain_ctrl,
  output logic o_mclk_enable,
  output logic [3:0] o_load_cap,
  output logic o_osc_running,
  // interface status
  output logic [7:0] o_lock_state
);
  rli_pkg::rli_lock_t lock;
  logic busy, auto_read_enable, short_strobe;
  logic [3:0] sel;
  logic [7:0] data;
  logic key_wr, adr_wr, dat_wr, key_rd, adr_rd, dat_rd;
  logic locked_any, unlocked;
  logic start_rd, start_wr, core_req, core_wr, core_done;
  logic [7:0] core_rdata;
  logic core_wr_q;
  logic [3:0] req_addr;
  logic block_sel;
  logic [7:0] state_code;

  assign key_wr = i_reg_wr && i_reg_addr == rli_pkg::KEY_OFS;
  assign adr_wr = i_reg_wr && i_reg_addr == rli_pkg::ADDR_OFS;
  assign dat_wr = i_reg_wr && i_reg_addr == rli_pkg::DATA_OFS;
  assign key_rd = i_reg_rd && i_reg_addr == rli_pkg::KEY_OFS;
  assign adr_rd = i_reg_rd && i_reg_addr == rli_pkg::ADDR_OFS;
  assign dat_rd = i_reg_rd && i_reg_addr == rli_pkg::DATA_OFS;
  assign locked_any = lock == rli_pkg::RLI_LOCKED || lock == rli_pkg::RLI_FIRST_KEY;
  assign unlocked = lock == rli_pkg::RLI_UNLOCKED;

  // lock and key state machine
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock <= rli_pkg::RLI_LOCKED;
    end else if (locked_any && (adr_wr || dat_wr || adr_rd || dat_rd)) begin
      lock <= rli_pkg::RLI_DISABLED;
    end else if (key_wr) begin
      unique case (lock)
        rli_pkg::RLI_LOCKED: begin
          lock <= (i_reg_wdata == rli_pkg::KEY_FIRST) ? rli_pkg::RLI_FIRST_KEY
                                                      : rli_pkg::RLI_DISABLED;
        end
        rli_pkg::RLI_FIRST_KEY: begin
          lock <= (i_reg_wdata == rli_pkg::KEY_SECOND) ? rli_pkg::RLI_UNLOCKED
                                                       : rli_pkg::RLI_DISABLED;
        end
        rli_pkg::RLI_UNLOCKED: lock <= rli_pkg::RLI_LOCKED;
        rli_pkg::RLI_DISABLED: lock <= rli_pkg::RLI_DISABLED;
      endcase
    end
  end

  always_comb begin
    unique case (lock)
      rli_pkg::RLI_LOCKED: state_code = rli_pkg::ST_LOCKED;
      rli_pkg::RLI_FIRST_KEY: state_code = rli_pkg::ST_FIRST_KEY;
      rli_pkg::RLI_UNLOCKED: state_code = rli_pkg::ST_UNLOCKED;
      rli_pkg::RLI_DISABLED: state_code = rli_pkg::ST_DISABLED;
    endcase
  end
  assign o_lock_state = state_code;

  // transfer starts, only while unlocked and idle
  assign start_rd = unlocked && !busy &&
                    ((adr_wr && i_reg_wdata[rli_pkg::BUSY_BIT]) || (dat_rd && auto_read_enable));
  assign start_wr = unlocked && !busy && dat_wr;
  assign core_req = start_rd || start_wr;
  assign core_wr = start_wr;
  // a combined select and busy write reads the newly written address
  assign req_addr = adr_wr ? i_reg_wdata[3:0] : sel;

  // address control fields; bit 5 has no storage
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      auto_read_enable <= 1'b0;
      short_strobe <= 1'b0;
      sel <= rli_pkg::SEL_RST;
    end else if (unlocked && !busy && adr_wr) begin
      auto_read_enable <= i_reg_wdata[rli_pkg::AUTO_READ_ENABLE_BIT];
      short_strobe <= i_reg_wdata[rli_pkg::SHORT_BIT];
      sel <= i_reg_wdata[3:0];
    end else if (core_done && block_sel) begin
      sel <= sel + 4'd1;
    end
  end

  assign block_sel = sel <= rli_pkg::IA_CAPTURE3 ||
                     (sel >= rli_pkg::IA_ALARM0 && sel <= rli_pkg::IA_ALARM3);

  // busy from start until the core reports completion
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy <= 1'b0;
    end else if (core_req) begin
      busy <= 1'b1;
    end else if (core_done) begin
      busy <= 1'b0;
    end
  end

  // indirect data register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data <= rli_pkg::DATA_RST;
    end else if (start_wr) begin
      data <= i_reg_wdata;
    end else if (core_done && !core_wr_q) begin
      data <= core_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_wr_q <= 1'b0;
    end else if (core_req) begin
      core_wr_q <= core_wr;
    end
  end

  // host read data, one cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (key_rd) begin
        o_reg_rdata <= state_code;
      end else if (adr_rd && unlocked) begin
        o_reg_rdata <= {busy, auto_read_enable, 1'b0, short_strobe, sel};
      end else if (dat_rd && unlocked) begin
        o_reg_rdata <= data;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  rli_clock_core u_core (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_osc_clk(i_osc_clk),
    .i_req(core_req),
    .i_wr(core_wr),
    .i_short(short_strobe),
    .i_addr(req_addr),
    .i_wdata(i_reg_wdata),
    .o_done(core_done),
    .o_rdata(core_rdata),
    .i_clock_valid(i_clock_valid),
    .i_load_ready(i_load_ready),
    .i_osc_fail(i_osc_fail),
    .o_osc_power(o_osc_power),
    .o_osc_crystal(o_osc_crystal),
    .o_bias_double(o_bias_double),
    .o_gain_ctrl(o_gain_ctrl),
    .o_mclk_enable(o_mclk_enable),
    .o_load_cap(o_load_cap),
    .o_osc_running(o_osc_running)
  );

  sequence s_first_key;
    lock == rli_pkg::RLI_LOCKED && key_wr && i_reg_wdata == rli_pkg::KEY_FIRST &&
      !(adr_wr || dat_wr || adr_rd || dat_rd);
  endsequence
  sequence s_second_key;
    key_wr && i_reg_wdata == rli_pkg::KEY_SECOND;
  endsequence

  a_key_pair: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    s_first_key ##1 (!i_reg_wr && !i_reg_rd) ##1 s_second_key |=> lock == rli_pkg::RLI_UNLOCKED)
    else $error("key pair did not unlock");
  a_bad_second: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (lock == rli_pkg::RLI_FIRST_KEY && key_wr && i_reg_wdata != rli_pkg::KEY_SECOND)
    |=> lock == rli_pkg::RLI_DISABLED) else $error("bad second key not disabling");
  a_relock_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (unlocked && key_wr) |=> lock == rli_pkg::RLI_LOCKED) else $error("key write did not relock");
  a_disabled_sticky: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    lock == rli_pkg::RLI_DISABLED |=> lock == rli_pkg::RLI_DISABLED) else $error("disabled state left");
  a_locked_access: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (locked_any && (adr_wr || dat_wr || dat_rd)) |=> lock == rli_pkg::RLI_DISABLED)
    else $error("locked access not disabling");
  a_status_read: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    key_rd |=> o_reg_rdata == $past(state_code)) else $error("status read mismatch");
  a_bit5_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    adr_rd |=> !o_reg_rdata[rli_pkg::UNUSED_BIT]) else $error("unused bit reads one");
  a_busy_start: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    start_rd |=> busy) else $error("busy not raised by read");
  a_busy_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (busy && !core_done) |=> busy) else $error("busy dropped early");
  a_read_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (start_rd && short_strobe) |-> ##[1:40] core_done) else $error("short read too slow");
  a_autoread: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (unlocked && !busy && auto_read_enable && dat_rd) |=> busy) else $error("auto-read did not start");
  a_addr_incr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (core_done && block_sel) |=> sel == $past(sel) + 4'd1) else $error("address not incremented");
  a_write_start: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    start_wr |=> busy && data == $past(i_reg_wdata)) else $error("data write not started");
endmodule

// file: rli_clock_core.sv
module rli_clock_core (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // oscillator timebase
  input wire logic i_osc_clk,
  // transfer request
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_short,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_done,
  output logic [7:0] o_rdata,
  // oscillator status
  input wire logic i_clock_valid,
  input wire logic i_load_ready,
  input wire logic i_osc_fail,
  // oscillator controls
  output logic o_osc_power,
  output logic o_osc_crystal,
  output logic o_bias_double,
  output logic o_gain_ctrl,
  output logic o_mclk_enable,
  output logic [3:0] o_load_cap,
  output logic o_osc_running
);
  logic sync0, sync1, sync2;
  logic osc_edge;
  logic pend, pend_wr;
  logic [1:0] edges;
  logic [3:0] pend_addr;
  logic [7:0] pend_data;
  logic [7:0] bytes [8];
  logic [7:0] clock_ctrl, osc_ctrl, osc_cfg;
  logic [7:0] next_rdata;
  logic fire;

  // oscillator timebase brought into the system domain
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync0 <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync0 <= i_osc_clk;
      sync1 <= sync0;
      sync2 <= sync1;
    end
  end
  assign osc_edge = sync1 & ~sync2;

  // transfer waits one or two oscillator edges
  assign fire = pend && osc_edge &&
                (edges + 2'd1 >= (i_short ? rli_pkg::EDGES_SHORT : rli_pkg::EDGES_LONG));

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      edges <= 2'd0;
      pend_addr <= rli_pkg::SEL_RST;
      pend_data <= rli_pkg::DATA_RST;
    end else if (i_req && !pend) begin
      pend <= 1'b1;
      pend_wr <= i_wr;
      edges <= 2'd0;
      pend_addr <= i_addr;
      pend_data <= i_wdata;
    end else if (fire) begin
      pend <= 1'b0;
    end else if (pend && osc_edge) begin
      edges <= edges + 2'd1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= fire;
    end
  end

  // internal register storage
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        bytes[i] <= rli_pkg::INT_RST;
      end
      clock_ctrl <= rli_pkg::INT_RST;
      osc_ctrl <= rli_pkg::INT_RST;
      osc_cfg <= rli_pkg::INT_RST;
    end else if (fire && pend_wr) begin
      unique case (pend_addr)
        rli_pkg::IA_CLOCK_CTRL: clock_ctrl <= pend_data;
        rli_pkg::IA_OSC_CTRL: osc_ctrl <= pend_data;
        rli_pkg::IA_OSC_CFG: osc_cfg <= pend_data;
        default: begin
          if (pend_addr <= rli_pkg::IA_CAPTURE3 || (pend_addr >= rli_pkg::IA_ALARM0 &&
              pend_addr <= rli_pkg::IA_ALARM3)) begin
            bytes[{pend_addr[3], pend_addr[1:0]}] <= pend_data;
          end
        end
      endcase
    end
  end

  // read view with live status bits
  always_comb begin
    next_rdata = 8'h00;
    unique case (pend_addr)
      rli_pkg::IA_CLOCK_CTRL: begin
        next_rdata = clock_ctrl;
        next_rdata[rli_pkg::CC_FAIL_BIT] = i_osc_fail;
      end
      rli_pkg::IA_OSC_CTRL: begin
        next_rdata = osc_ctrl;
        next_rdata[rli_pkg::OC_VALID_BIT] = i_clock_valid;
      end
      rli_pkg::IA_OSC_CFG: begin
        next_rdata = osc_cfg;
        next_rdata[rli_pkg::CF_READY_BIT] = i_load_ready;
      end
      default: begin
        if (pend_addr <= rli_pkg::IA_CAPTURE3 || (pend_addr >= rli_pkg::IA_ALARM0 &&
            pend_addr <= rli_pkg::IA_ALARM3)) begin
          next_rdata = bytes[{pend_addr[3], pend_addr[1:0]}];
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= rli_pkg::DATA_RST;
    end else if (fire && !pend_wr) begin
      o_rdata <= next_rdata;
    end
  end

  assign o_osc_power = clock_ctrl[rli_pkg::CC_POWER_BIT];
  assign o_mclk_enable = clock_ctrl[rli_pkg::CC_MCLK_BIT];
  assign o_osc_crystal = osc_ctrl[rli_pkg::OC_MODE_BIT];
  assign o_bias_double = osc_ctrl[rli_pkg::OC_BIAS_BIT];
  assign o_gain_ctrl = osc_ctrl[rli_pkg::OC_GAIN_BIT];
  assign o_load_cap = osc_cfg[3:0];
  // self-oscillate runs at once, crystal needs the valid detector
  assign o_osc_running = o_osc_power && (!o_osc_crystal || i_clock_valid);

  a_self_osc_run: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (o_osc_power && !o_osc_crystal) |-> o_osc_running) else $error("self-oscillate not running");
  a_short_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (fire && i_short) |-> (edges == 2'd0)) else $error("short strobe waited too long");
endmodule

// file: rli_host_model.sv
module rli_host_model (
  // clock
  input wire logic i_sys_clk,
  // register port
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // one write strobe, data inverted once released
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #2;
    o_reg_addr = addr;
    o_reg_wdata = data;
    o_reg_wr = 1'b1;
    @(posedge i_sys_clk);
    #2;
    o_reg_wr = 1'b0;
    o_reg_wdata = ~data;
  endtask

  // one read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_sys_clk);
    #2;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(posedge i_sys_clk);
    #2;
    o_reg_rd = 1'b0;
    data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
  endtask

  // ordered key pair
  task automatic unlock();
    wr(rli_pkg::KEY_OFS, rli_pkg::KEY_FIRST);
    wr(rli_pkg::KEY_OFS, rli_pkg::KEY_SECOND);
  endtask

  // poll the busy flag before touching data
  task automatic wait_idle(output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 400; i++) begin
      rd(rli_pkg::ADDR_OFS, v);
      if (v[rli_pkg::BUSY_BIT] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule

// file: rli_pkg.sv
package rli_pkg;
  // host register map
  localparam logic [7:0] KEY_OFS = 8'h0a;
  localparam logic [7:0] ADDR_OFS = 8'h0b;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  // key codes and interface status codes
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ST_LOCKED = 8'h00;
  localparam logic [7:0] ST_FIRST_KEY = 8'h01;
  localparam logic [7:0] ST_UNLOCKED = 8'h02;
  localparam logic [7:0] ST_DISABLED = 8'h03;
  // indirect address control fields
  localparam int BUSY_BIT = 7;
  localparam int AUTO_READ_ENABLE_BIT = 6;
  localparam int UNUSED_BIT = 5;
  localparam int SHORT_BIT = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] SEL_RST = 4'h0;
  // internal clock register addresses
  localparam logic [3:0] IA_CAPTURE0 = 4'h0;
  localparam logic [3:0] IA_CAPTURE3 = 4'h3;
  localparam logic [3:0] IA_CLOCK_CTRL = 4'h4;
  localparam logic [3:0] IA_OSC_CTRL = 4'h5;
  localparam logic [3:0] IA_OSC_CFG = 4'h6;
  localparam logic [3:0] IA_ALARM0 = 4'h8;
  localparam logic [3:0] IA_ALARM3 = 4'hb;
  // internal register fields
  localparam int CC_POWER_BIT = 7;
  localparam int CC_MCLK_BIT = 6;
  localparam int CC_FAIL_BIT = 5;
  localparam int OC_GAIN_BIT = 7;
  localparam int OC_MODE_BIT = 6;
  localparam int OC_BIAS_BIT = 5;
  localparam int OC_VALID_BIT = 4;
  localparam int CF_READY_BIT = 7;
  localparam logic [7:0] INT_RST = 8'h00;
  // oscillator edges to wait per transfer
  localparam logic [1:0] EDGES_SHORT = 2'd1;
  localparam logic [1:0] EDGES_LONG = 2'd2;

  typedef enum logic [1:0] {
    RLI_LOCKED,
    RLI_FIRST_KEY,
    RLI_UNLOCKED,
    RLI_DISABLED
  } rli_lock_t;
endpackage

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic osc_clk = 1'b0;
  logic clock_valid = 1'b0;
  logic load_ready = 1'b0;
  logic osc_fail = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic osc_power;
  logic osc_crystal;
  logic bias_double;
  logic gain_ctrl;
  logic mclk_enable;
  logic [3:0] load_cap;
  logic osc_running;
  logic [7:0] lock_state;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #25 i_sys_clk = ~i_sys_clk;
  always #365 osc_clk = ~osc_clk;

  rli_access u_dut (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd),
    .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid),
    .i_osc_clk(osc_clk),
    .i_clock_valid(clock_valid),
    .i_load_ready(load_ready),
    .i_osc_fail(osc_fail),
    .o_osc_power(osc_power),
    .o_osc_crystal(osc_crystal),
    .o_bias_double(bias_double),
    .o_gain_ctrl(gain_ctrl),
    .o_mclk_enable(mclk_enable),
    .o_load_cap(load_cap),
    .o_osc_running(osc_running),
    .o_lock_state(lock_state)
  );

  rli_host_model u_host (
    .i_sys_clk(i_sys_clk),
    .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd),
    .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid)
  );

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic do_reset();
    @(posedge i_sys_clk);
    #2;
    i_sys_rst = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    #2;
    i_sys_rst = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(addr, v);
    check8(v, exp);
  endtask

  task automatic idle_chk();
    logic ok;
    u_host.wait_idle(ok);
    check8({7'h00, ok}, 8'h01);
  endtask

  // first key then a wrong second key
  task automatic t_keys();
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_LOCKED);
    u_host.wr(rli_pkg::KEY_OFS, rli_pkg::KEY_FIRST);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_FIRST_KEY);
    u_host.wr(rli_pkg::KEY_OFS, 8'h00);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_DISABLED);
    check8(lock_state, rli_pkg::ST_DISABLED);
  endtask

  // indirect access while locked
  task automatic t_locked_access();
    rd_chk(rli_pkg::ADDR_OFS, 8'h00);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_DISABLED);
  endtask

  task automatic t_unlock_relock();
    u_host.unlock();
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_UNLOCKED);
    u_host.wr(rli_pkg::KEY_OFS, 8'h77);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_LOCKED);
    u_host.unlock();
    check8(lock_state, rli_pkg::ST_UNLOCKED);
  endtask

  // oscillator mode, bias and power through indirect writes
  task automatic t_osc();
    u_host.wr(rli_pkg::ADDR_OFS, 8'h15);
    u_host.wr(rli_pkg::DATA_OFS, 8'h40);
    idle_chk();
    check8({6'h00, osc_crystal, bias_double}, 8'h02);
    u_host.wr(rli_pkg::ADDR_OFS, 8'h14);
    u_host.wr(rli_pkg::DATA_OFS, 8'h80);
    idle_chk();
    check8({6'h00, osc_power, osc_running}, 8'h02);
    clock_valid = 1'b1;
    @(posedge i_sys_clk);
    #2;
    check8({7'h00, osc_running}, 8'h01);
    clock_valid = 1'b0;
    u_host.wr(rli_pkg::ADDR_OFS, 8'h15);
    u_host.wr(rli_pkg::DATA_OFS, 8'h20);
    idle_chk();
    check8({5'h00, osc_crystal, bias_double, osc_running}, 8'h03);
  endtask

  // crystal start and external clock check, host side sequence
  task automatic t_crystal();
    u_host.wr(rli_pkg::ADDR_OFS, 8'h15);
    u_host.wr(rli_pkg::DATA_OFS, 8'hc0);
    idle_chk();
    u_host.wr(rli_pkg::ADDR_OFS, 8'h16);
    u_host.wr(rli_pkg::DATA_OFS, 8'h0a);
    idle_chk();
    check8({1'b0, gain_ctrl, osc_crystal, bias_double, load_cap}, 8'h6a);
    u_host.wr(rli_pkg::ADDR_OFS, 8'h14);
    u_host.wr(rli_pkg::DATA_OFS, 8'h80);
    idle_chk();
    clock_valid = 1'b1;
    load_ready = 1'b1;
    u_host.wr(rli_pkg::ADDR_OFS, 8'h95);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'hd0);
    u_host.wr(rli_pkg::ADDR_OFS, 8'h96);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'h8a);
    u_host.wr(rli_pkg::ADDR_OFS, 8'h14);
    u_host.wr(rli_pkg::DATA_OFS, 8'hc0);
    idle_chk();
    check8({5'h00, osc_power, mclk_enable, osc_running}, 8'h07);
    clock_valid = 1'b0;
    load_ready = 1'b0;
    u_host.wr(rli_pkg::ADDR_OFS, 8'h15);
    u_host.wr(rli_pkg::DATA_OFS, 8'h40);
    idle_chk();
    check8({5'h00, gain_ctrl, osc_crystal, bias_double}, 8'h02);
    osc_fail = 1'b1;
    u_host.wr(rli_pkg::ADDR_OFS, 8'h94);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'he0);
    osc_fail = 1'b0;
  endtask

  // alarm block write, auto increment and auto-read
  task automatic t_alarm();
    logic [7:0] v;
    u_host.wr(rli_pkg::ADDR_OFS, 8'h28);
    rd_chk(rli_pkg::ADDR_OFS, 8'h08);
    u_host.wr(rli_pkg::DATA_OFS, 8'h11);
    idle_chk();
    u_host.wr(rli_pkg::DATA_OFS, 8'h22);
    idle_chk();
    rd_chk(rli_pkg::ADDR_OFS, 8'h0a);
    u_host.wr(rli_pkg::ADDR_OFS, 8'hd8);
    u_host.rd(rli_pkg::ADDR_OFS, v);
    check8({7'h00, v[rli_pkg::BUSY_BIT]}, 8'h01);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'h11);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'h22);
    idle_chk();
    u_host.wr(rli_pkg::ADDR_OFS, 8'h97);
    idle_chk();
    rd_chk(rli_pkg::DATA_OFS, 8'h00);
    rd_chk(8'h0d, 8'h00);
  endtask

  // wrong first key disables, further keys ignored
  task automatic t_disable();
    u_host.wr(rli_pkg::KEY_OFS, 8'h00);
    u_host.wr(rli_pkg::KEY_OFS, 8'h5a);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_DISABLED);
    u_host.wr(rli_pkg::KEY_OFS, rli_pkg::KEY_FIRST);
    rd_chk(rli_pkg::KEY_OFS, rli_pkg::ST_DISABLED);
    rd_chk(rli_pkg::DATA_OFS, 8'h00);
  endtask

  initial begin
    do_reset();
    t_keys();
    do_reset();
    t_locked_access();
    do_reset();
    t_unlock_relock();
    t_osc();
    t_crystal();
    t_alarm();
    t_disable();
    results();
  end
endmodule
